// *** verilog/alin_pkg.sv ***
// Shared constants and types for the angle linearization datapath.
// Assumes a single pclk domain; no other package is needed.
package alin_pkg;
    localparam int ANGLE_W      = 16;
    localparam int COEFF_W      = 8;
    localparam int NUM_COEFF    = 16;
    localparam int IDX_W        = 4;
    localparam int NUM_PATH     = 4;
    localparam int PATH_IDX_W   = 2;
    localparam int FRAC_W       = ANGLE_W - IDX_W;
    localparam int CORR_SHIFT   = 3;

    localparam logic [11:0] ADDR_CTRL      = 12'h000;
    localparam logic [11:0] ADDR_STATUS    = 12'h004;
    localparam logic [11:0] ADDR_COEFF_LO  = 12'h100;
    localparam logic [11:0] ADDR_COEFF_HI  = 12'h1FC;
    localparam int          CTRL_EN_BIT    = 0;
    localparam int          CTRL_BYP_BIT   = 1;
    localparam logic [1:0]  CTRL_RESET     = 2'h1;
    localparam logic [7:0]  COEFF_RESET    = 8'h00;
    localparam logic [31:0] READ_ZERO      = 32'h0000_0000;

    typedef logic [ANGLE_W-1:0] alin_angle_t;
    typedef logic signed [COEFF_W-1:0] alin_coeff_t;
endpackage

// *** verilog/alin_interp.sv ***
// One linearization stage: interpolates the correction and adds it to the angle.
// Assumes coefficients are supplied as a flat vector and stable while in use.
`timescale 1ns/10ps
module alin_interp
    import alin_pkg::*;
(
    input  wire logic                          pclk,
    input  wire logic                          presetn,
    input  wire logic                          in_valid,
    input  wire logic [ANGLE_W-1:0]            in_angle,
    input  wire logic                          bypass,
    input  wire logic [NUM_COEFF*COEFF_W-1:0]  coeffs,
    output logic                               out_valid,
    output logic [ANGLE_W-1:0]                 out_angle
);
    // Full circle maps onto 2^ANGLE_W codes; the top four bits pick the 22.5 degree segment.
    wire  [IDX_W-1:0]          seg_lo  = in_angle[ANGLE_W-1 -: IDX_W]; // [RULE5]
    wire  [IDX_W-1:0]          seg_hi  = seg_lo + 4'h1;                 // [RULE9]
    wire  [FRAC_W-1:0]         frac    = in_angle[FRAC_W-1:0];
    wire  signed [COEFF_W-1:0] y0      = coeffs[seg_lo*COEFF_W +: COEFF_W]; // [RULE3] [RULE4] [RULE7]
    wire  signed [COEFF_W-1:0] y1      = coeffs[seg_hi*COEFF_W +: COEFF_W];
    wire  signed [COEFF_W:0]   dy      = {y1[COEFF_W-1], y1} - {y0[COEFF_W-1], y0};
    wire  signed [COEFF_W+FRAC_W+1:0] prod = dy * $signed({1'b0, frac});
    wire  signed [COEFF_W+1:0] step    = (COEFF_W+2)'(prod >>> FRAC_W);
    wire  signed [COEFF_W+1:0] corr    = {{2{y0[COEFF_W-1]}}, y0} + step; // [RULE6]
    // One coefficient step is 1/4096 of a turn; the angle word is 1/65536, so scale by 16.
    wire  signed [ANGLE_W-1:0] corr_a  = ANGLE_W'(corr) <<< (CORR_SHIFT + 1); // [RULE8]
    wire  [ANGLE_W-1:0]        next_angle = bypass ? in_angle : in_angle + corr_a; // [RULE2]

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_valid <= 1'b0;
            out_angle <= '0;
        end else begin
            out_valid <= in_valid;
            if (in_valid) begin
                out_angle <= next_angle;
            end
        end
    end
endmodule

// *** verilog/alin_top.sv ***
// Angle linearization for the main and three redundant paths, with APB coefficient storage.
// Assumes angle samples arrive on pclk; coefficients are loaded from nonvolatile storage by software.
//
// Overview of operation
// [RULE1] Four independent stages: main plus three redundant paths, each own coefficients.
// [RULE2] Output angle is measured angle plus signed correction.
// [RULE3] Correction depends on angle, taken from loaded stored coefficients.
// [RULE4] Sixteen coefficients per path, breakpoints every 22.5 degrees from zero.
// [RULE5] Coefficient k applies at angle k times 22.5 degrees.
// [RULE6] Between breakpoints, linearly interpolate the two nearest coefficients.
// [RULE7] Coefficients are 8-bit two's complement, range -128 to 127.
// [RULE8] One coefficient step equals about 0.088 degrees of correction.
// [RULE9] Above 337.5 degrees interpolate between index 15 and index 0.
`timescale 1ns/10ps
module alin_top
    import alin_pkg::*;
#(
    parameter int PATHS = NUM_PATH
)
(
    input  wire logic                        pclk,
    input  wire logic                        presetn,
    input  wire logic                        psel,
    input  wire logic                        penable,
    input  wire logic                        pwrite,
    input  wire logic [11:0]                 paddr,
    input  wire logic [31:0]                 pwdata,
    output logic [31:0]                      prdata,
    output logic                             pready,
    output logic                             pslverr,
    input  wire logic [PATHS-1:0]            angle_valid,
    input  wire logic [PATHS*ANGLE_W-1:0]    angle_in,
    output logic [PATHS-1:0]                 corr_valid,
    output logic [PATHS*ANGLE_W-1:0]         corr_angle
);
    import alin_pkg::*;

    initial begin
        if (PATHS != NUM_PATH) begin
            $error("alin_top supports exactly four paths");
        end
    end

    // ********************************************
    // Register file
    // ********************************************
    logic [1:0]   ctrl;
    logic [COEFF_W-1:0] coeff_mem [PATHS*NUM_COEFF];

    wire        acc       = psel && penable && !pready;
    wire        wr        = acc && pwrite;
    wire        is_ctrl   = paddr == ADDR_CTRL;
    wire        is_status = paddr == ADDR_STATUS;
    wire        is_coeff  = paddr >= ADDR_COEFF_LO && paddr <= ADDR_COEFF_HI && paddr[1:0] == 2'h0;
    wire        mapped    = is_ctrl || is_status || is_coeff;
    wire [5:0]  cidx      = 6'((paddr - ADDR_COEFF_LO) >> 2);
    logic [PATHS-1:0] seen;
    wire [31:0] rd_val    = is_ctrl   ? {30'h0000_0000, ctrl} :
                            is_status ? {28'h000_0000, seen} :
                            is_coeff  ? {24'h00_0000, coeff_mem[cidx]} : READ_ZERO;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= READ_ZERO;
            ctrl    <= CTRL_RESET;
        end else begin
            pready  <= acc;
            pslverr <= acc && !mapped;
            prdata  <= (acc && !pwrite) ? rd_val : READ_ZERO;
            if (wr && is_ctrl) begin
                ctrl <= pwdata[1:0];
            end
        end
    end

    // Coefficient storage, one signed byte per breakpoint per path.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < PATHS*NUM_COEFF; i++) begin
                coeff_mem[i] <= COEFF_RESET;
            end
        end else if (wr && is_coeff) begin
            coeff_mem[cidx] <= pwdata[COEFF_W-1:0]; // [RULE3]
        end
    end

    // ********************************************
    // Datapath, one stage per path
    // ********************************************
    genvar p;
    generate
        for (p = 0; p < PATHS; p++) begin : g_path
            logic [NUM_COEFF*COEFF_W-1:0] flat;
            logic                         v;
            logic [ANGLE_W-1:0]           a;
            for (genvar k = 0; k < NUM_COEFF; k++) begin : g_c
                assign flat[k*COEFF_W +: COEFF_W] = coeff_mem[p*NUM_COEFF+k]; // [RULE1] [RULE4]
            end
            alin_interp u_stage (
                .pclk      (pclk),
                .presetn   (presetn),
                .in_valid  (angle_valid[p] && ctrl[CTRL_EN_BIT]),
                .in_angle  (angle_in[p*ANGLE_W +: ANGLE_W]),
                .bypass    (ctrl[CTRL_BYP_BIT]),
                .coeffs    (flat),
                .out_valid (v),
                .out_angle (a)
            );
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    corr_valid[p]                   <= 1'b0;
                    corr_angle[p*ANGLE_W +: ANGLE_W] <= '0;
                    seen[p]                         <= 1'b0;
                end else begin
                    corr_valid[p] <= v;
                    if (v) begin
                        corr_angle[p*ANGLE_W +: ANGLE_W] <= a;
                    end
                    // Sticky sample-seen flag; a new sample wins over a clear in the same cycle.
                    if (v) begin
                        seen[p] <= 1'b1;
                    end else if (wr && is_status && pwdata[p]) begin
                        seen[p] <= 1'b0;
                    end
                end
            end
        end
    endgenerate
endmodule

// *** tb/alin_monitor.sv ***
// Checker of bus timing and result timing of the main path and the last redundant path.
// Assumes it is bound into alin_top.
`timescale 1ns/10ps
module alin_monitor
    import alin_pkg::*;
#(parameter int PATHS = NUM_PATH)
(
    input wire logic                     pclk, presetn, psel, penable, pwrite, pready, pslverr,
    input wire logic [11:0]              paddr,
    input wire logic [31:0]              prdata,
    input wire logic [PATHS-1:0]         angle_valid, corr_valid,
    input wire logic [PATHS*ANGLE_W-1:0] corr_angle
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_wait;
        psel && penable && !pready;
    endsequence
    chk_one_wait: assert property (s_wait |=> pready) else $error("no answer after one wait");
    chk_ready_pulse: assert property (pready |=> !pready) else $error("pready too long");
    chk_err_ready: assert property (pslverr |-> pready) else $error("pslverr alone");
    chk_err_unmapped: assert property (pready && paddr > ADDR_COEFF_HI |-> pslverr) else $error("no pslverr");
    chk_coeff_ok: assert property (pready && paddr >= ADDR_COEFF_LO && paddr[1:0] == 2'b00
        && paddr <= ADDR_COEFF_HI |-> !pslverr) else $error("coefficient refused");
    chk_idle_rdata: assert property (!pready |-> prdata == READ_ZERO) else $error("prdata not 0");
    chk_err_rdata: assert property (pslverr && !pwrite |-> prdata == READ_ZERO) else $error("bad err data");
    chk_main_lat: assert property (corr_valid[0] |-> $past(angle_valid[0], 2))
        else $error("main result latency");
    chk_red_lat: assert property (corr_valid[PATHS-1] |-> $past(angle_valid[PATHS-1], 2))
        else $error("redundant result latency");
    chk_out_hold: assert property (corr_valid == '0 |-> $stable(corr_angle)) else $error("result moved");
endmodule
bind alin_top alin_monitor #(.PATHS(PATHS)) mon_u (.pclk, .presetn, .psel, .penable, .pwrite,
    .pready, .pslverr, .paddr, .prdata, .angle_valid, .corr_valid, .corr_angle);

// *** tb/alin_front.sv ***
// Front-end stand-in: one angle sample to all four paths.
// Assumes send is called right after a clock edge.
`timescale 1ns/10ps
module alin_front (
    input wire logic    pclk,
    output logic [3:0]  valid,
    output logic [63:0] angle
);
    initial begin
        valid = '0;
        angle = '0;
    end
    // Outside a sample the angle bus shows the bitwise inverse of the last sample, never the last value.
    task send(input logic [15:0] a);
        @(posedge pclk);
        valid <= 4'hF;
        angle <= {4{a}};
        @(posedge pclk);
        valid <= 4'h0;
        angle <= ~{4{a}};
    endtask
endmodule

// *** tb/test_angle_linearization.sv ***
// Bench: loads coefficients over the bus, then checks corrected angles.
// Assumes alin_front drives the angle inputs.
`timescale 1ns/10ps
module test_angle_linearization;
    import alin_pkg::*;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, er;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd;
    logic [3:0]  angle_valid, corr_valid;
    logic [63:0] angle_in, corr_angle;
    logic [15:0] tab[6] = '{16'h0000, 16'h7000, 16'h1800, 16'hF800, 16'hFFFF, 16'h0005};
    int          fail_count = 0, checked = 0, n;
    always #5 pclk = ~pclk;
    alin_top dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .angle_valid, .angle_in, .corr_valid, .corr_angle);
    alin_front fe_u (.pclk, .valid(angle_valid), .angle(angle_in));
    task end_sim;
        $display("checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task cmp(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED %0t got %h want %h", $time, got, exp);
        end
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
        @(posedge pclk);
        penable <= 1;
        n = 0;
        do @(posedge pclk); while (pready !== 1'b1 && ++n < 20);
        rd = prdata;
        er = pslverr;
        {psel, penable} <= 2'b00;
        if (n >= 20) begin fail_count++; end_sim; end
    endtask
    function automatic logic signed [7:0] cf(int p, int k);
        return 8'(k * 23 + p * 61 + 128);
    endfunction
    // Correction in coefficient steps, sixteen angle codes each.
    function automatic logic [15:0] expv(int p, logic [15:0] a);
        int y0, y1;
        y0 = cf(p, a[15:12]);
        y1 = cf(p, (a[15:12] + 1) % 16);
        return 16'(int'(a) + 16 * (y0 + (((y1 - y0) * int'(a[11:0])) >>> 12)));
    endfunction
    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1;
        apb(0, ADDR_CTRL, 0); cmp(rd, 32'h0000_0001);
        apb(0, ADDR_COEFF_HI, 0); cmp(rd, 32'h0000_0000);
        for (int i = 0; i < 64; i++) apb(1, 12'(ADDR_COEFF_LO + 4 * i), 32'(cf(i / 16, i % 16)));
        apb(0, ADDR_COEFF_LO, 0); cmp(rd, {24'h0000_00, cf(0, 0)});
        apb(0, 12'h800, 0); cmp(32'(er), 32'h0000_0001);
        cmp(rd, 32'h0000_0000);
        $display("register test done");
        foreach (tab[i]) begin
            fe_u.send(tab[i]);
            n = 0;
            do @(posedge pclk); while (corr_valid !== 4'hF && ++n < 8);
            if (n >= 8) begin fail_count++; end_sim; end
            for (int p = 0; p < 4; p++) cmp(corr_angle[16*p +: 16], expv(p, tab[i]));
        end
        $display("interpolation test done");
        apb(0, ADDR_STATUS, 0); cmp(rd, 32'h0000_000F);
        apb(1, ADDR_STATUS, 32'h0000_000F);
        apb(0, ADDR_STATUS, 0); cmp(rd, 32'h0000_0000);
        apb(1, ADDR_CTRL, 32'h0000_0003);
        fe_u.send(16'h4321);
        n = 0;
        do @(posedge pclk); while (corr_valid !== 4'hF && ++n < 8);
        if (n >= 8) begin fail_count++; end_sim; end
        for (int p = 0; p < 4; p++) cmp(corr_angle[16*p +: 16], 16'h4321);
        $display("status and bypass test done");
        apb(1, ADDR_CTRL, 0);
        fe_u.send(16'h1234);
        repeat (3) @(posedge pclk) cmp(corr_valid, 0);
        $display("disable test done");
        end_sim;
    end
endmodule
